// File: rtl/resolver_regs.vh
`ifndef RESOLVER_REGS_VH
`define RESOLVER_REGS_VH
// cache geometry
`define CACHE_DEPTH 128
`define CACHE_IDX_W 7
`define CACHE_LAST 7'h7f
// records probed per search step, and the base index of the last group
`define PROBES 4
`define PROBE_STEP 7'h04
`define LAST_GROUP 7'h7c
`define MAC_W 48
`define KEY_W 64
`define STAMP_W 32
// requester count and its index width
`define NUM_REQ 4
`define REQ_IDX_W 2
// refresh period in clock cycles (20 ns each), default about 1 s
`define REFRESH_CYCLES 32'h02fa_f080
// arp request frame length in bytes and its last index
`define ARP_LEN 6'h2a
`define ARP_LAST 6'h29
// arp field constants
`define ETH_ARP 16'h0806
`define HW_ETH 16'h0001
`define PROTO_IP4 16'h0800
`define ARP_OP_REQ 16'h0001
`define BCAST_MAC 48'hffff_ffff_ffff
`endif

// File: rtl/arp_request_sender.v
`timescale 1ns/1ns
`include "resolver_regs.vh"
module arp_request_sender (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [31:0] target_ip,
  input wire [47:0] own_mac,
  input wire [31:0] own_ip,
  input wire tx_cts,
  output reg busy,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_sof,
  output reg tx_eof
);
  reg [5:0] idx;
  reg [31:0] tip;
  reg [335:0] frame;
  // frame image: broadcast dest, arp header, who-has target
  always @* begin
    frame = {`BCAST_MAC, own_mac, `ETH_ARP, `HW_ETH, `PROTO_IP4,
             8'h06, 8'h04, `ARP_OP_REQ, own_mac, own_ip,
             48'h0000_0000_0000, tip};
  end
  // byte serialiser, paced by the mac clear-to-send
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      idx <= 6'h00;
      tip <= 32'h0000_0000;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      tx_sof <= 1'b0;
      tx_eof <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          idx <= 6'h00;
          tip <= target_ip;
        end
      end else if (tx_cts) begin
        tx_data <= frame[335 - idx*8 -: 8];
        tx_valid <= 1'b1;
        tx_sof <= (idx == 6'h00);
        tx_eof <= (idx == `ARP_LAST);
        if (idx == `ARP_LAST)
          busy <= 1'b0;
        idx <= idx + 6'h01;
      end
    end
  end
endmodule // arp_request_sender

// File: rtl/address_cache.v
`timescale 1ns/1ns
`include "resolver_regs.vh"
// Operation
// - cache holds 128 address records
// - record: mac, network key, timestamp
// - learn pairs from arp and ip packets
// - overwrite oldest record next
// - search key, return matching mac
// - miss or stale triggers arp request, dropped while the sender is busy
// - lookup finishes in bounded time
// - one cache, arbiter serialises requesters
// - sender broadcasts assembled arp request
module address_cache (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [3:0] REQ,
  input wire [255:0] REQ_KEY,
  input wire LEARN,
  input wire [63:0] LEARN_KEY,
  input wire [47:0] LEARN_MAC,
  input wire [47:0] OWN_MAC,
  input wire [31:0] OWN_IP,
  input wire MAC_TX_CTS,
  output reg [3:0] RESULT_VALID,
  output reg RESULT_HIT,
  output reg [47:0] RESULT_MAC,
  output wire ARP_BUSY,
  output wire [7:0] MAC_TX_DATA,
  output wire MAC_TX_VALID,
  output wire MAC_TX_SOF,
  output wire MAC_TX_EOF
);
  localparam S_IDLE = 2'b00;
  localparam S_SEARCH = 2'b01;
  localparam S_DONE = 2'b10;
  reg [47:0] mac_mem [0:127];
  reg [63:0] key_mem [0:127];
  reg [31:0] stamp_mem [0:127];
  reg [127:0] used;
  reg [1:0] state;
  reg [1:0] grant;
  reg [1:0] rr;
  reg [6:0] ptr;
  reg [6:0] oldest;
  reg [31:0] now;
  reg [63:0] key;
  reg arp_start;
  reg [31:0] arp_ip;
  // learn pipeline: index found for the learned key
  reg [6:0] lrn_hit_idx;
  reg lrn_hit;
  // search lanes: first matching record of the current group
  reg [6:0] grp_idx;
  reg grp_hit;
  reg [6:0] lane;
  integer i;
  integer j;
  // a record matches only when it holds data and its key agrees
  // keeps empty slots with a zero key from answering a zero lookup
  function match;
    input valid;
    input [63:0] stored;
    input [63:0] want;
    begin
      match = valid && (stored == want);
    end
  endfunction
  // age test; modulo subtraction survives the stamp counter wrapping
  function stale;
    input [31:0] t_now;
    input [31:0] t_rec;
    begin
      stale = (t_now - t_rec) > `REFRESH_CYCLES;
    end
  endfunction
  // fixed-priority pick rotated from last grant for fairness
  function [2:0] pick;
    input [3:0] r;
    input [1:0] start;
    reg [1:0] k;
    integer n;
    begin
      pick = 3'b000;
      for (n = 3; n >= 0; n = n - 1) begin
        k = start + n[1:0] + 2'b01;
        if (r[k])
          pick = {1'b1, k};
      end
    end
  endfunction
  wire [2:0] sel = pick(REQ, rr);
  // free-running timestamp clock
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N)
      now <= 32'h0000_0000;
    else
      now <= now + 32'h0000_0001;
  end
  // find existing record for learned key
  always @* begin
    lrn_hit = 1'b0;
    lrn_hit_idx = 7'h00;
    for (i = 0; i < `CACHE_DEPTH; i = i + 1) begin
      if (match(used[i], key_mem[i], LEARN_KEY)) begin
        lrn_hit = 1'b1;
        lrn_hit_idx = i[6:0];
      end
    end
  end
  // four lanes per clock bound the search to 32 steps
  // lanes are scanned downwards so the lowest matching index wins
  // trade-off: four comparators per step against a slower one-lane scan
  always @* begin
    grp_hit = 1'b0;
    grp_idx = 7'h00;
    lane = 7'h00;
    for (j = `PROBES - 1; j >= 0; j = j - 1) begin
      lane = ptr + j[6:0];
      if (match(used[lane], key_mem[lane], key)) begin
        grp_hit = 1'b1;
        grp_idx = lane;
      end
    end
  end
  // learning writes refresh in place or replace the oldest
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      used <= 128'h0;
      oldest <= 7'h00;
    end else if (LEARN) begin
      if (lrn_hit) begin
        mac_mem[lrn_hit_idx] <= LEARN_MAC;
        stamp_mem[lrn_hit_idx] <= now;
      end else begin
        mac_mem[oldest] <= LEARN_MAC;
        key_mem[oldest] <= LEARN_KEY;
        stamp_mem[oldest] <= now;
        used[oldest] <= 1'b1;
        oldest <= oldest + 7'h01; // ring order keeps oldest next
      end
    end
  end
  // lookup engine: four records per clock, so time tracks location
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_IDLE;
      grant <= 2'b00;
      rr <= 2'b11;
      ptr <= 7'h00;
      key <= 64'h0;
      RESULT_VALID <= 4'h0;
      RESULT_HIT <= 1'b0;
      RESULT_MAC <= 48'h0;
      arp_start <= 1'b0;
      arp_ip <= 32'h0000_0000;
    end else begin
      RESULT_VALID <= 4'h0;
      arp_start <= 1'b0;
      case (state)
        S_IDLE: begin
          if (sel[2]) begin
            grant <= sel[1:0];
            rr <= sel[1:0];
            key <= REQ_KEY[sel[1:0]*64 +: 64];
            ptr <= 7'h00;
            state <= S_SEARCH;
          end
        end
        S_SEARCH: begin
          if (grp_hit) begin
            RESULT_MAC <= mac_mem[grp_idx];
            // stale record still answers but refreshes
            RESULT_HIT <= 1'b1;
            if (stale(now, stamp_mem[grp_idx])) begin
              arp_start <= 1'b1;
              arp_ip <= key[31:0];
            end
            state <= S_DONE;
          end else if (ptr == `LAST_GROUP) begin
            RESULT_HIT <= 1'b0;
            RESULT_MAC <= 48'h0;
            arp_start <= 1'b1;
            arp_ip <= key[31:0];
            state <= S_DONE;
          end
          ptr <= ptr + `PROBE_STEP;
        end
        S_DONE: begin
          // bounded answer after at most 32 steps
          // a miss answers on the 34th clock after the request is seen, well inside the time budget
          RESULT_VALID[grant] <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  arp_request_sender sender (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .start(arp_start),
    .target_ip(arp_ip),
    .own_mac(OWN_MAC),
    .own_ip(OWN_IP),
    .tx_cts(MAC_TX_CTS),
    .busy(ARP_BUSY),
    .tx_data(MAC_TX_DATA),
    .tx_valid(MAC_TX_VALID),
    .tx_sof(MAC_TX_SOF),
    .tx_eof(MAC_TX_EOF)
  );
endmodule // address_cache

// File: dv/resolver_properties.sv
`timescale 1ns/1ns
module resolver_checker (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [3:0] REQ,
  input wire [3:0] RESULT_VALID,
  input wire RESULT_HIT,
  input wire [47:0] RESULT_MAC,
  input wire ARP_BUSY,
  input wire [7:0] MAC_TX_DATA,
  input wire MAC_TX_VALID,
  input wire MAC_TX_SOF,
  input wire MAC_TX_EOF
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // a miss answer, shared by two checks
  wire miss = |RESULT_VALID && !RESULT_HIT;
  // one quiet cycle, then the answer within the worst queue wait
  sequence ans0;
    !RESULT_VALID[0] ##[1:600] RESULT_VALID[0];
  endsequence
  resp_win_a: assert property ($rose(REQ[0]) |=> ans0)
    else $error("answer late");
  grant_req_a: assert property (
    |RESULT_VALID |-> !(RESULT_VALID & ~$past(REQ))) else $error("grant");
  one_grant_a: assert property ($onehot0(RESULT_VALID))
    else $error("two grants");
  miss_zero_a: assert property (miss |-> RESULT_MAC == 48'h0)
    else $error("miss mac");
  miss_arp_a: assert property (miss |-> ##[0:4] ARP_BUSY)
    else $error("no arp");
  sof_bcast_a: assert property (
    MAC_TX_SOF |-> MAC_TX_VALID && MAC_TX_DATA == 8'hff) else $error("sof");
  eof_last_a: assert property (
    MAC_TX_EOF |-> MAC_TX_VALID && !MAC_TX_SOF) else $error("eof");
  mid_busy_a: assert property (
    MAC_TX_VALID && !MAC_TX_EOF |-> ARP_BUSY) else $error("busy");
endmodule // resolver_checker
bind address_cache resolver_checker resolver_checker_inst (.*);

// File: dv/tx_requesters.sv
`timescale 1ns/1ns
module tx_requesters (
  input wire clk,
  input wire [3:0] go,
  input wire [3:0] valid,
  output reg [3:0] req,
  output reg cts
);
  initial req = 4'h0;
  initial cts = 1'b0;
  // hold until answered
  // off the sampling edge; the mac stalls every other cycle
  always @(negedge clk) begin
    req <= (req & ~valid) | go;
    cts <= ~cts;
  end
endmodule // tx_requesters

// File: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  reg SYS_CLK = 1'b0, RST_N = 1'b0, LEARN = 1'b0;
  reg [3:0] go = 4'h0;
  reg [255:0] REQ_KEY = 256'h0;
  reg [63:0] LEARN_KEY = 64'h0;
  reg [47:0] LEARN_MAC = 48'h0, OWN_MAC = 48'h0200_0000_0001;
  reg [31:0] OWN_IP = 32'h0a00_0002;
  wire [3:0] REQ, RESULT_VALID;
  wire [47:0] RESULT_MAC;
  wire [7:0] MAC_TX_DATA;
  wire MAC_TX_CTS, RESULT_HIT, ARP_BUSY, MAC_TX_VALID, MAC_TX_SOF, MAC_TX_EOF;
  int miscompares = 0, n_tests = 0, i, c;
  address_cache address_cache_inst (.*);
  tx_requesters tx_requesters_inst (.clk(SYS_CLK), .go(go),
    .valid(RESULT_VALID), .req(REQ), .cts(MAC_TX_CTS));
  // 50 MHz
  always #10 SYS_CLK = ~SYS_CLK;
  task give_verdict;
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [63:0] g, input [63:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // bounded wait on edges; a hang ends the run as a failure
  task wt(input [3:0] m);
    c = 0;
    do begin @(posedge SYS_CLK); #1 c++; end
    while ((RESULT_VALID & m) === 4'h0 && c < 3000 && !(m == 0 && MAC_TX_EOF));
    if (c >= 3000) begin miscompares++; give_verdict; end
  endtask
  task learn(input [63:0] k, input [47:0] m);
    @(negedge SYS_CLK); LEARN <= 1'b1; LEARN_KEY <= k; LEARN_MAC <= m;
    @(negedge SYS_CLK); LEARN <= 1'b0;
  endtask
  // one requester asks; answer, mac and cycle count judged
  task ask(input int n, input [63:0] k, input h, input [47:0] m, input int x);
    @(negedge SYS_CLK); REQ_KEY[64*n+:64] <= k; go[n] <= 1'b1;
    @(negedge SYS_CLK); go[n] <= 1'b0;
    wt(4'h1 << n);
    chk(RESULT_HIT, h);
    chk(RESULT_MAC, m);
    chk(c, x + 3);
  endtask
  // broadcast frame after a miss, counted byte by byte under stalls
  task s_frame;
    i = 0;
    c = 0;
    do begin
      @(posedge SYS_CLK); #1 c++;
      i += MAC_TX_VALID;
    end while (!MAC_TX_EOF && c < 3000);
    if (c >= 3000) begin miscompares++; give_verdict; end
    chk(i, 42);
  endtask
  // two requesters at once; each gets its own mac
  task s_arb;
    @(negedge SYS_CLK); REQ_KEY[127:0] <= {64'h9, 64'h7}; go <= 4'h3;
    @(negedge SYS_CLK); go <= 4'h0;
    repeat (2) begin
      wt(4'h3);
      chk(RESULT_MAC, RESULT_VALID[0] ? 48'h5000 + 7 : 48'h5000 + 9);
    end
  endtask
  initial begin
    repeat (5) @(negedge SYS_CLK);
    RST_N = 1'b1;
    chk(RESULT_VALID, 0);
    ask(0, 64'h0a00_0001, 1'b0, 48'h0, 31);
    s_frame;
    for (int j = 1; j <= 128; j++) learn(j, 48'h5000 + j);
    ask(1, 128, 1'b1, 48'h5000 + 128, 31);
    ask(2, 5, 1'b1, 48'h5000 + 5, 1);
    learn(200, 48'h1234);
    ask(3, 1, 1'b0, 48'h0, 31);
    ask(0, 200, 1'b1, 48'h1234, 0);
    s_arb;
    give_verdict;
  end
endmodule // testbench
